// ==== sramc_asserts.sv ====
// pin timing assertions for the sram host controller
`include "sramc_consts.svh"
module sramc_asserts (
  input wire logic                     clk_in,
  input wire logic                     nrst_in,
  input wire logic                     done_out,
  input wire logic [`SRAMC_ADDR_W-1:0] mem_addr_out,
  input wire logic                     chip_sel_n_out,
  input wire logic                     write_strobe_n_out,
  input wire logic                     out_gate_n_out,
  input wire logic                     upper_lane_sel_n_out,
  input wire logic                     lower_lane_sel_n_out,
  input wire logic                     mem_data_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_pulse;
    $fell(write_strobe_n_out) ##2 $rose(write_strobe_n_out);
  endsequence
  sequence s_close;
    ##1 (done_out && chip_sel_n_out && !mem_data_oe_out);
  endsequence
  a_write_walk: assert property (s_pulse |-> s_close) else $error("write close wrong");
  a_strobe_width: assert property ($fell(write_strobe_n_out) |-> out_gate_n_out ##1
    (!write_strobe_n_out && out_gate_n_out) ##1 write_strobe_n_out) else $error("strobe width");
  a_select_end: assert property ($rose(write_strobe_n_out) |-> !$past(chip_sel_n_out))
    else $error("select short");
  a_addr_stable: assert property (!write_strobe_n_out |-> $stable(mem_addr_out) && !chip_sel_n_out)
    else $error("address moved");
  a_data_setup: assert property ($rose(write_strobe_n_out) |-> $past(mem_data_oe_out)
    && mem_data_oe_out) else $error("data setup");
  a_float_wait: assert property ($fell(write_strobe_n_out) |-> !mem_data_oe_out)
    else $error("data driven early");
  a_lane_end: assert property ($rose(write_strobe_n_out) |-> !($past(upper_lane_sel_n_out)
    && $past(lower_lane_sel_n_out))) else $error("no lane");
  a_read_strobe: assert property (!out_gate_n_out |-> write_strobe_n_out && !mem_data_oe_out)
    else $error("strobe in read");
  a_read_select: assert property (!out_gate_n_out |-> !chip_sel_n_out)
    else $error("gate without select");
  a_cycle_min: assert property ($fell(chip_sel_n_out) |=> !chip_sel_n_out)
    else $error("cycle short");
endmodule : sramc_asserts
bind sramc_ctrl sramc_asserts u_chk (.clk_in, .nrst_in, .done_out, .mem_addr_out,
  .chip_sel_n_out, .write_strobe_n_out, .out_gate_n_out, .upper_lane_sel_n_out,
  .lower_lane_sel_n_out, .mem_data_oe_out);

// ==== sramc_consts.svh ====
// timing constants, field positions and reset values for the sram host controller
`ifndef SRAMC_CONSTS_SVH
`define SRAMC_CONSTS_SVH
`define SRAMC_CLK_PERIOD_NS        10
`define SRAMC_ADDR_W               17
`define SRAMC_DATA_W               16
`define SRAMC_LANE_LO              0
`define SRAMC_LANE_HI              1
`define SRAMC_WRITE_CYCLE_MIN_NS   10
`define SRAMC_SELECT_TO_END_NS     7
`define SRAMC_ADDR_TO_END_NS       7
`define SRAMC_STROBE_GATE_HIGH_NS  7
`define SRAMC_STROBE_GATE_LOW_NS   10
`define SRAMC_DATA_VALID_END_NS    5
`define SRAMC_LANE_SEL_TO_END_NS   7
`define SRAMC_STROBE_TO_FLOAT_NS   5
`define SRAMC_READ_CYCLE_MIN_NS    10
`define SRAMC_ACCESS_MAX_NS        10
`define SRAMC_CEIL_CYC(ns) (((ns) + `SRAMC_CLK_PERIOD_NS - 1) / `SRAMC_CLK_PERIOD_NS)
`define SRAMC_STROBE_CYC  `SRAMC_CEIL_CYC(`SRAMC_STROBE_GATE_HIGH_NS)
`define SRAMC_FLOAT_CYC   `SRAMC_CEIL_CYC(`SRAMC_STROBE_TO_FLOAT_NS)
// access time plus the three filter stages, so the filtered word has settled before capture
`define SRAMC_READ_CYC    (`SRAMC_CEIL_CYC(`SRAMC_ACCESS_MAX_NS) + 3)
`define SRAMC_RST_ADDR    17'h00000
`define SRAMC_RST_DATA    16'h0000
`endif

// ==== sramc_ctrl.sv ====
// host controller driving write and read cycles on an asynchronous 128k x 16 sram
`include "sramc_consts.svh"
module sramc_ctrl
  import sramc_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire logic                      wr_req_in,
  input  wire logic                      rd_req_in,
  input  wire logic [`SRAMC_ADDR_W-1:0]  addr_in,
  input  wire logic [`SRAMC_DATA_W-1:0]  wdata_in,
  input  wire logic [1:0]                lane_en_in,
  output logic                           busy_out,
  output logic                           done_out,
  output logic [`SRAMC_DATA_W-1:0]       rdata_out,
  output logic [`SRAMC_ADDR_W-1:0]       mem_addr_out,
  output logic                           chip_sel_n_out,
  output logic                           write_strobe_n_out,
  output logic                           out_gate_n_out,
  output logic                           upper_lane_sel_n_out,
  output logic                           lower_lane_sel_n_out,
  output logic [`SRAMC_DATA_W-1:0]       mem_data_out,
  output logic                           mem_data_oe_out,
  input  wire logic [`SRAMC_DATA_W-1:0]  mem_data_in
);
  localparam logic [2:0] STROBE_CYC = 3'(`SRAMC_STROBE_CYC);
  localparam logic [2:0] FLOAT_CYC  = 3'(`SRAMC_FLOAT_CYC);
  localparam logic [2:0] READ_CYC   = 3'(`SRAMC_READ_CYC);

  sramc_state_t                state_q;
  logic [2:0]                  cnt_q;
  logic [`SRAMC_DATA_W-1:0]    rd_sync;

  sramc_sync #(
    .W (`SRAMC_DATA_W)
  ) u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (mem_data_in),
    .q_out   (rd_sync)
  );

  // sequencer; the gate is held high on writes so the shorter strobe width applies
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= SRAMC_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      unique case (state_q)
        SRAMC_IDLE: begin
          cnt_q <= 3'h0;
          // writes with a lane enabled win when both requests arrive together; with no lane the read is taken
          if (wr_req_in && lane_en_in != 2'h0) begin
            state_q <= SRAMC_WSET;
          end else if (rd_req_in) begin
            state_q <= SRAMC_RSET;
          end
        end
        // one cycle of address setup ahead of the strobe
        SRAMC_WSET: begin
          state_q <= SRAMC_WPULS;
          cnt_q   <= 3'h1;
        end
        // strobe held for the rounded-up width and past the float count, two cycles here
        SRAMC_WPULS: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q >= STROBE_CYC && cnt_q > FLOAT_CYC) begin
            state_q <= SRAMC_WEND;
          end
        end
        // strobe risen; address may change next cycle
        SRAMC_WEND: begin
          state_q <= SRAMC_IDLE;
        end
        // address placed before chip select falls
        SRAMC_RSET: begin
          state_q <= SRAMC_RWAIT;
          cnt_q   <= 3'h0;
        end
        // wait covers access time plus synchroniser delay
        SRAMC_RWAIT: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q >= READ_CYC) begin
            state_q <= SRAMC_REND;
          end
        end
        SRAMC_REND: begin
          state_q <= SRAMC_IDLE;
        end
        default: begin
          state_q <= SRAMC_IDLE;
        end
      endcase
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_addr_out         <= `SRAMC_RST_ADDR;
      chip_sel_n_out       <= 1'b1;
      write_strobe_n_out   <= 1'b1;
      out_gate_n_out       <= 1'b1;
      upper_lane_sel_n_out <= 1'b1;
      lower_lane_sel_n_out <= 1'b1;
      mem_data_out         <= `SRAMC_RST_DATA;
      mem_data_oe_out      <= 1'b0;
    end else begin
      unique case (state_q)
        SRAMC_IDLE: begin
          chip_sel_n_out     <= 1'b1;
          write_strobe_n_out <= 1'b1;
          out_gate_n_out     <= 1'b1;
          mem_data_oe_out    <= 1'b0;
          if (wr_req_in && lane_en_in != 2'h0) begin
            // address launched on the same edge as select and lanes, held through the whole cycle
            mem_addr_out         <= addr_in;
            mem_data_out         <= wdata_in;
            // lanes and select asserted ahead of the strobe
            chip_sel_n_out       <= 1'b0;
            upper_lane_sel_n_out <= ~lane_en_in[`SRAMC_LANE_HI];
            lower_lane_sel_n_out <= ~lane_en_in[`SRAMC_LANE_LO];
          end else if (rd_req_in) begin
            mem_addr_out         <= addr_in;
            upper_lane_sel_n_out <= 1'b0;
            lower_lane_sel_n_out <= 1'b0;
          end else begin
            upper_lane_sel_n_out <= 1'b1;
            lower_lane_sel_n_out <= 1'b1;
          end
        end
        SRAMC_WSET: begin
          // strobe falls only with select and a lane already low
          write_strobe_n_out <= 1'b0;
        end
        SRAMC_WPULS: begin
          // drive data only once the memory has floated its pins
          if (cnt_q >= FLOAT_CYC) begin
            mem_data_oe_out <= 1'b1;
          end
          // select, lanes and data held until the strobe rises
          if (cnt_q >= STROBE_CYC && cnt_q > FLOAT_CYC) begin
            write_strobe_n_out <= 1'b1;
          end
        end
        SRAMC_WEND: begin
          // data released with the write already ended
          mem_data_oe_out      <= 1'b0;
          chip_sel_n_out       <= 1'b1;
          upper_lane_sel_n_out <= 1'b1;
          lower_lane_sel_n_out <= 1'b1;
        end
        SRAMC_RSET: begin
          // select and gate drop together and stay low
          chip_sel_n_out  <= 1'b0;
          out_gate_n_out  <= 1'b0;
        end
        SRAMC_RWAIT: begin
          write_strobe_n_out <= 1'b1;
        end
        SRAMC_REND: begin
          chip_sel_n_out       <= 1'b1;
          out_gate_n_out       <= 1'b1;
          upper_lane_sel_n_out <= 1'b1;
          lower_lane_sel_n_out <= 1'b1;
        end
        default: begin
          write_strobe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // user side status
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_out  <= 1'b0;
      done_out  <= 1'b0;
      rdata_out <= `SRAMC_RST_DATA;
    end else begin
      busy_out <= (state_q == SRAMC_IDLE) ? ((wr_req_in && lane_en_in != 2'h0) || rd_req_in)
                                          : (state_q != SRAMC_WEND && state_q != SRAMC_REND);
      done_out <= (state_q == SRAMC_WEND) || (state_q == SRAMC_REND);
      if (state_q == SRAMC_REND) begin
        rdata_out <= rd_sync;
      end
    end
  end
endmodule : sramc_ctrl

// ==== sramc_mem_model.sv ====
// behavioural model of the asynchronous 128k x 16 memory
module sramc_mem_model (
  input  wire logic [16:0] addr_in,
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        gate_n_in,
  input  wire logic        upper_n_in,
  input  wire logic        lower_n_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [logic [16:0]];
  logic [16:0] a_q;
  logic [15:0] d_q, w_q, word, hold_q;
  logic [1:0]  l_q;
  wire wr_act = !cs_n_in && !we_n_in && !(upper_n_in && lower_n_in);
  wire rd_act = !cs_n_in && !gate_n_in && we_n_in;
  assign word = mem.exists(addr_in) ? mem[addr_in] : 16'h0000;
  always @* if (wr_act) begin
    a_q = addr_in;
    d_q = data_in;
    l_q = {!upper_n_in, !lower_n_in};
  end
  always @(negedge wr_act) begin
    w_q = mem.exists(a_q) ? mem[a_q] : 16'h0000;
    if (l_q[1]) w_q[15:8] = d_q[15:8];
    if (l_q[0]) w_q[7:0] = d_q[7:0];
    mem[a_q] = w_q;
  end
  initial hold_q = 16'h0000;
  always @(rd_act, word) if (rd_act) hold_q = word;
  // float unless reading; floating shows inverse
  assign data_out = rd_act ? word : ~hold_q;
endmodule : sramc_mem_model

// ==== sramc_pkg.sv ====
// types for the sram host controller
package sramc_pkg;
  typedef enum logic [2:0] {
    SRAMC_IDLE  = 3'b000,
    SRAMC_WSET  = 3'b001,
    SRAMC_WPULS = 3'b010,
    SRAMC_WEND  = 3'b011,
    SRAMC_RSET  = 3'b100,
    SRAMC_RWAIT = 3'b101,
    SRAMC_REND  = 3'b110
  } sramc_state_t;
endpackage : sramc_pkg

// ==== sramc_sync.sv ====
// three-flop synchroniser for the sram data pins, change taken when stages two and three agree
module sramc_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // per-bit filter: a bit moves only once two stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          q_out[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          q_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : sramc_sync

// ==== tb.sv ====
// self-checking bench for the sram host controller
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, nrst_in, wr_req_in, rd_req_in, busy_out, done_out, chip_sel_n_out;
  logic write_strobe_n_out, out_gate_n_out, upper_lane_sel_n_out, lower_lane_sel_n_out;
  logic        mem_data_oe_out;
  logic [1:0]  lane_en_in;
  logic [16:0] addr_in, mem_addr_out;
  logic [15:0] wdata_in, rdata_out, mem_data_out, mem_data_in, mdl_q;
  int num_errors = 0, n_tests = 0, cyc = 0;
  assign mem_data_in = mem_data_oe_out ? mem_data_out : mdl_q;
  sramc_ctrl dut (.clk_in, .nrst_in, .wr_req_in, .rd_req_in, .addr_in, .wdata_in, .lane_en_in,
    .busy_out, .done_out, .rdata_out, .mem_addr_out, .chip_sel_n_out, .write_strobe_n_out,
    .out_gate_n_out, .upper_lane_sel_n_out, .lower_lane_sel_n_out, .mem_data_out,
    .mem_data_oe_out, .mem_data_in);
  sramc_mem_model u_mem (.addr_in(mem_addr_out), .cs_n_in(chip_sel_n_out),
    .we_n_in(write_strobe_n_out), .gate_n_in(out_gate_n_out), .upper_n_in(upper_lane_sel_n_out),
    .lower_n_in(lower_lane_sel_n_out), .data_in(mem_data_in), .data_out(mdl_q));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task access(input logic w, input logic [16:0] a, input logic [15:0] d, input logic [1:0] l);
    int n;
    @(posedge clk_in); #1;
    {wr_req_in, rd_req_in, addr_in, wdata_in, lane_en_in} = {w, !w, a, d, l};
    @(posedge clk_in); #1;
    {wr_req_in, rd_req_in} = 2'b00;
    chk(busy_out, 1'b1);
    n = 0;
    while (done_out !== 1'b1 && n < 20) begin
      @(posedge clk_in); #1;
      n++;
    end
    // write ends four edges after accept, read seven
    chk(n, w ? 4 : 7);
    chk(busy_out, 1'b0);
  endtask : access
  task rd_chk(input logic [16:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000, 2'b11);
    chk(rdata_out, exp);
  endtask : rd_chk
  task t_reset;
    chk({chip_sel_n_out, write_strobe_n_out, out_gate_n_out, upper_lane_sel_n_out,
      lower_lane_sel_n_out, mem_data_oe_out, busy_out, done_out}, 8'hF8);
    $display("test reset done");
  endtask : t_reset
  task t_lanes;
    access(1'b1, 17'h00155, 16'h1234, 2'b11);
    rd_chk(17'h00155, 16'h1234);
    access(1'b1, 17'h00155, 16'hABCD, 2'b10);
    rd_chk(17'h00155, 16'hAB34);
    access(1'b1, 17'h00155, 16'h5566, 2'b01);
    rd_chk(17'h00155, 16'hAB66);
    $display("test lanes done");
  endtask : t_lanes
  task t_no_lane;
    @(posedge clk_in); #1;
    {wr_req_in, addr_in, wdata_in, lane_en_in} = {1'b1, 17'h00155, 16'hFFFF, 2'b00};
    // watched every cycle: a started write would show select or strobe low
    repeat (6) begin
      @(posedge clk_in); #1;
      chk({busy_out, chip_sel_n_out, write_strobe_n_out}, 3'b011);
    end
    wr_req_in = 1'b0;
    rd_chk(17'h00155, 16'hAB66);
    $display("test no lane done");
  endtask : t_no_lane
  task t_b2b;
    access(1'b1, 17'h1FFFF, 16'hC3A5, 2'b11);
    access(1'b1, 17'h00000, 16'h5A3C, 2'b11);
    rd_chk(17'h1FFFF, 16'hC3A5);
    rd_chk(17'h00000, 16'h5A3C);
    $display("test back to back done");
  endtask : t_b2b
  task stop_test;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ceiling well above the roughly one hundred cycles needed
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    {nrst_in, wr_req_in, rd_req_in, addr_in, wdata_in, lane_en_in} = '0;
    repeat (16) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    t_reset();
    t_lanes();
    t_no_lane();
    t_b2b();
    stop_test();
  end
endmodule : tb
